// File: rtl/rdp_dummy_end.sv
// unused

// File: rtl/rdp_pin_cell.sv
// one port pin: general-purpose control with priority claim by alternate functions
`timescale 1ns/100ps
module rdp_pin_cell (
   input wire logic dir,
   input wire logic dout,
   input wire logic pull,
   input wire logic drive,
   input wire logic slew,
   input rdp_pkg::rdp_alt_t alt,
   output rdp_pkg::rdp_pad_t pad
);
   import rdp_pkg::*;
   // later alternates override earlier ones, so the highest enabled one owns the pin
   always_comb begin
      pad.oe = dir;
      pad.dout = dout;
      for (int k = 0; k < NALT; k++) begin
         if (alt.en[k]) begin
            pad.oe = alt.oe[k];
            pad.dout = alt.dout[k];
         end
      end
      pad.pull = pull & ~pad.oe;
      pad.drive = drive & pad.oe;
      pad.slew = slew & pad.oe;
   end
endmodule // rdp_pin_cell

// File: rtl/rdp_pin_ctl.sv
// reset-out, debug/mode-select and port pin control behind an AXI4-Lite slave
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Function
// - after power-on the reset-out pin is a port pin until enabled by software
// - once reset-out is selected it stays until the next power-on reset
// - enabled reset-out drives low during chip reset, high otherwise
// - enabled reset-out pin is output only, its input path unused
// - reset-out enable and reset-input enable act independently
// - during power-on or forced reset the debug pin is a mode-select input
// - right after any reset the debug pin carries the debug link
// - while debug enable is set the debug pin pull-up is on
// - every reset sets debug enable; software clears it to free the pin
// - an open mode-select pin gives normal mode at reset release
// - each debug link bit lasts 16 bus clock cycles
// - device adds a brief driven-high speed-up pulse after driving low
// - after reset port pins are high-impedance inputs without pull-up
// - software picks drive strength and slew for outputs, pull-up for inputs
// - data reads follow the direction bit even when a peripheral owns the pin
// - the highest priority enabled alternate function owns a shared pin
// - enabled reset input is input only with pull-up, sticky until power-on
module rdp_pin_ctl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [rdp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rdp_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sys_reset_req,
   input wire logic [rdp_pkg::PORT_W-1:0] pad_in,
   input rdp_pkg::rdp_alt_t [rdp_pkg::PORT_W-1:0] alt_i,
   output rdp_pkg::rdp_pad_t [rdp_pkg::PORT_W-1:0] pad_o,
   output logic chip_reset_n,
   output logic bgnd_mode
);
   import rdp_pkg::*;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [7:0] wdata;
      logic wstb;
      logic reset_out_pin_enable;
      logic reset_input_pin_enable;
      logic debug_pin_enable;
      logic chip_rstn;
      logic [RST_CNT_W-1:0] rst_cnt;
      logic mode_src;
      logic bgnd;
      logic [PORT_W-1:0] dir;
      logic [PORT_W-1:0] dout;
      logic [PORT_W-1:0] pull;
      logic [PORT_W-1:0] drive;
      logic [PORT_W-1:0] slew;
      logic dbg_prev;
      logic bit_busy;
      logic [3:0] bit_cnt;
      logic bit_drv_low;
      logic [7:0] tx_sh;
      logic [3:0] tx_left;
      logic [7:0] rx_sh;
      logic [3:0] rx_cnt;
      rdp_pad_t [PORT_W-1:0] pad;
   } rdp_state_t;
   rdp_state_t st_ff;
   rdp_state_t nxt_st;
   logic [PORT_W-1:0] pin_s;
   rdp_pad_t [PORT_W-1:0] gp_pad;

   // pin levels come from outside the clock domain
   rdp_sync #(.W(PORT_W)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d_i(pad_in),
      .q_o(pin_s)
   );

   // general-purpose controls merged with alternate function claims
   for (genvar i = 0; i < PORT_W; i++) begin : g_cell
      rdp_pin_cell u_cell (
         .dir(st_ff.dir[i]),
         .dout(st_ff.dout[i]),
         .pull(st_ff.pull[i]),
         .drive(st_ff.drive[i]),
         .slew(st_ff.slew[i]),
         .alt(alt_i[i]),
         .pad(gp_pad[i])
      );
   end

   // next state: bus slave, option bits, chip reset, debug link and pads
   always_comb begin
      logic wr;
      logic frc_wr;
      logic rst_req;
      logic rx_clr;
      logic dbg_fall;
      logic mapped;
      logic [PORT_W-1:0] din;
      logic [31:0] rd;
      logic [3:0] rx_base;
      nxt_st = st_ff;
      frc_wr = 1'b0;
      rx_clr = 1'b0;
      wr = 1'b0;
      rst_req = 1'b0;
      dbg_fall = 1'b0;
      mapped = 1'b0;
      din = '0;
      rd = 32'h0;
      rx_base = 4'h0;
      // port reads follow the direction bit, not the buffer owner
      for (int i = 0; i < PORT_W; i++) begin
         din[i] = st_ff.dir[i] ? st_ff.dout[i] : pin_s[i];
      end
      if (st_ff.reset_out_pin_enable) begin
         din[PIN_RESET_OUT] = 1'b0;
      end
      // write address and data are taken in either order
      if (s_axi_awvalid && st_ff.awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata[7:0];
         nxt_st.wstb = s_axi_wstrb[0];
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
      unique case (st_ff.awaddr)
         OFS_SYSOPT, OFS_FORCE, OFS_STATUS, OFS_DIR, OFS_DOUT, OFS_DIN, OFS_PULL,
         OFS_DRIVE, OFS_SLEW, OFS_DBG_TX, OFS_DBG_RX: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      if (wr) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = mapped ? RESP_OKAY : RESP_SLVERR;
      end
      // register write effects, low byte lane only
      if (wr && st_ff.wstb) begin
         unique case (st_ff.awaddr)
            OFS_SYSOPT: begin
               nxt_st.reset_out_pin_enable = st_ff.reset_out_pin_enable |
                  st_ff.wdata[BIT_RESET_OUT_EN];
               nxt_st.reset_input_pin_enable = st_ff.reset_input_pin_enable |
                  st_ff.wdata[BIT_RESET_IN_EN];
               nxt_st.debug_pin_enable = st_ff.wdata[BIT_DEBUG_EN];
            end
            OFS_FORCE: frc_wr = st_ff.wdata[BIT_FORCE];
            OFS_DIR: nxt_st.dir = st_ff.wdata[PORT_W-1:0];
            OFS_DOUT: nxt_st.dout = st_ff.wdata[PORT_W-1:0];
            OFS_PULL: nxt_st.pull = st_ff.wdata[PORT_W-1:0];
            OFS_DRIVE: nxt_st.drive = st_ff.wdata[PORT_W-1:0];
            OFS_SLEW: nxt_st.slew = st_ff.wdata[PORT_W-1:0];
            OFS_DBG_TX: begin
               if (st_ff.tx_left == 4'h0) begin
                  nxt_st.tx_sh = st_ff.wdata;
                  nxt_st.tx_left = DBG_BYTE_BITS;
               end
            end
            default: ;
         endcase
      end
      // read channel, one read at a time
      unique case (s_axi_araddr)
         OFS_SYSOPT: rd = {29'h0, st_ff.debug_pin_enable, st_ff.reset_input_pin_enable,
                           st_ff.reset_out_pin_enable};
         OFS_STATUS: rd = {29'h0, st_ff.rx_cnt == DBG_BYTE_BITS, st_ff.tx_left != 4'h0,
                           st_ff.bgnd};
         OFS_DIR: rd = {24'h0, st_ff.dir};
         OFS_DOUT: rd = {24'h0, st_ff.dout};
         OFS_DIN: rd = {24'h0, din};
         OFS_PULL: rd = {24'h0, st_ff.pull};
         OFS_DRIVE: rd = {24'h0, st_ff.drive};
         OFS_SLEW: rd = {24'h0, st_ff.slew};
         OFS_DBG_TX: rd = {20'h0, st_ff.tx_left, st_ff.tx_sh};
         OFS_DBG_RX: rd = {20'h0, st_ff.rx_cnt, st_ff.rx_sh};
         default: rd = 32'h0;
      endcase
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_ff.arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd;
         nxt_st.rresp = (s_axi_araddr == OFS_FORCE || s_axi_araddr == OFS_SYSOPT ||
                         rd != 32'h0 || s_axi_araddr inside {OFS_STATUS, OFS_DIR,
                         OFS_DOUT, OFS_DIN, OFS_PULL, OFS_DRIVE, OFS_SLEW, OFS_DBG_TX,
                         OFS_DBG_RX}) ? RESP_OKAY : RESP_SLVERR;
         rx_clr = s_axi_araddr == OFS_DBG_RX; // reading the byte empties it
      end
      // debug link bit engine, 16 cycles per bit from the host's falling edge
      nxt_st.dbg_prev = pin_s[PIN_DEBUG];
      dbg_fall = st_ff.debug_pin_enable && st_ff.chip_rstn && st_ff.dbg_prev &&
                 !pin_s[PIN_DEBUG];
      rx_base = rx_clr ? 4'h0 : st_ff.rx_cnt;
      nxt_st.rx_cnt = rx_base;
      if (st_ff.bit_busy) begin
         nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
         if (st_ff.bit_cnt == DBG_SAMPLE && !st_ff.bit_drv_low) begin
            nxt_st.rx_sh = {st_ff.rx_sh[6:0], pin_s[PIN_DEBUG]};
            if (rx_base != DBG_BYTE_BITS) begin
               nxt_st.rx_cnt = rx_base + 4'h1; // new bit beats a read clear
            end
         end
         if (st_ff.bit_cnt == DBG_BIT_LAST) begin
            nxt_st.bit_busy = 1'b0;
         end
      end else if (dbg_fall) begin
         nxt_st.bit_busy = 1'b1;
         nxt_st.bit_cnt = 4'h0;
         nxt_st.bit_drv_low = (st_ff.tx_left != 4'h0) && !st_ff.tx_sh[7];
         if (st_ff.tx_left != 4'h0) begin
            nxt_st.tx_sh = {st_ff.tx_sh[6:0], 1'b0};
            nxt_st.tx_left = st_ff.tx_left - 4'h1;
         end
      end
      // chip reset sequencer and mode-select latch
      rst_req = sys_reset_req || frc_wr ||
                (st_ff.reset_input_pin_enable && !pin_s[PIN_RESET_IN]);
      if (rst_req) begin
         nxt_st.chip_rstn = 1'b0;
         nxt_st.rst_cnt = '0;
         nxt_st.mode_src = frc_wr;
      end else if (!st_ff.chip_rstn) begin
         if (st_ff.rst_cnt == RST_HOLD_CYC - 4'h1) begin
            nxt_st.chip_rstn = 1'b1;
            nxt_st.bgnd = st_ff.mode_src && !pin_s[PIN_DEBUG];
         end else begin
            nxt_st.rst_cnt = st_ff.rst_cnt + 4'h1;
         end
      end
      // every reset frees the port and hands the debug pin to the link
      if (!st_ff.chip_rstn) begin
         nxt_st.debug_pin_enable = DEBUG_EN_RST;
         nxt_st.dir = GPIO_RST;
         nxt_st.dout = GPIO_RST;
         nxt_st.pull = GPIO_RST;
         nxt_st.drive = GPIO_RST;
         nxt_st.slew = GPIO_RST;
         nxt_st.tx_left = 4'h0;
         nxt_st.rx_cnt = 4'h0;
         nxt_st.bit_busy = 1'b0;
      end
      // pads: alternate claims first, then the system functions on top
      nxt_st.pad = gp_pad;
      if (st_ff.debug_pin_enable) begin
         nxt_st.pad[PIN_DEBUG] = '0;
         nxt_st.pad[PIN_DEBUG].pull = 1'b1;
         if (st_ff.chip_rstn && st_ff.bit_busy && st_ff.bit_drv_low) begin
            if (st_ff.bit_cnt >= DBG_DRV_FIRST && st_ff.bit_cnt <= DBG_DRV_LAST) begin
               nxt_st.pad[PIN_DEBUG].oe = 1'b1;
            end
            if (st_ff.bit_cnt == DBG_SPEEDUP) begin
               nxt_st.pad[PIN_DEBUG].oe = 1'b1;
               nxt_st.pad[PIN_DEBUG].dout = 1'b1;
            end
         end
      end
      if (st_ff.reset_input_pin_enable) begin
         nxt_st.pad[PIN_RESET_IN] = '0;
         nxt_st.pad[PIN_RESET_IN].pull = 1'b1;
      end
      if (st_ff.reset_out_pin_enable) begin
         nxt_st.pad[PIN_RESET_OUT] = '0;
         nxt_st.pad[PIN_RESET_OUT].oe = 1'b1;
         nxt_st.pad[PIN_RESET_OUT].dout = st_ff.chip_rstn;
      end
      nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
      nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;
      nxt_st.arready = !nxt_st.rvalid;
      // power-on reset
      if (!aresetn) begin
         nxt_st = '0;
         nxt_st.debug_pin_enable = DEBUG_EN_RST;
         nxt_st.mode_src = 1'b1;
         nxt_st.dbg_prev = SYNC_RST;
         nxt_st.dir = GPIO_RST;
      end
   end

   always_ff @(posedge aclk) begin
      st_ff <= nxt_st;
   end

   // outputs straight from the state register
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign pad_o = st_ff.pad;
   assign chip_reset_n = st_ff.chip_rstn;
   assign bgnd_mode = st_ff.bgnd;

   // checks of the pin functions
   property p_ro_por;
      @(posedge aclk) $rose(aresetn) |->
         !st_ff.reset_out_pin_enable && !st_ff.pad[PIN_RESET_OUT].oe;
   endproperty
   a_ro_por: assert property (p_ro_por) else $error("reset-out enabled after power-on");
   property p_ro_sticky;
      @(posedge aclk) disable iff (!aresetn)
         st_ff.reset_out_pin_enable |=> st_ff.reset_out_pin_enable;
   endproperty
   a_ro_sticky: assert property (p_ro_sticky) else $error("reset-out enable lost");
   property p_ro_follow;
      @(posedge aclk) disable iff (!aresetn) st_ff.reset_out_pin_enable |=>
         st_ff.pad[PIN_RESET_OUT].oe && !st_ff.pad[PIN_RESET_OUT].pull &&
         st_ff.pad[PIN_RESET_OUT].dout == $past(st_ff.chip_rstn);
   endproperty
   a_ro_follow: assert property (p_ro_follow) else $error("reset-out not tracking");
   property p_dbg_set;
      @(posedge aclk) disable iff (!aresetn)
         !st_ff.chip_rstn ##1 st_ff.chip_rstn |-> st_ff.debug_pin_enable && st_ff.dir == GPIO_RST;
   endproperty
   a_dbg_set: assert property (p_dbg_set) else $error("pins not reset at release");
   property p_dbg_pull;
      @(posedge aclk) disable iff (!aresetn)
         st_ff.debug_pin_enable |=> st_ff.pad[PIN_DEBUG].pull;
   endproperty
   a_dbg_pull: assert property (p_dbg_pull) else $error("debug pin pull-up off");
   property p_bit_len;
      @(posedge aclk) disable iff (!aresetn || !st_ff.chip_rstn)
         $rose(st_ff.bit_busy) |-> st_ff.bit_cnt == 4'h0 ##15 st_ff.bit_cnt == DBG_BIT_LAST
            ##1 !st_ff.bit_busy;
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("debug bit not 16 cycles");
   property p_speedup;
      @(posedge aclk) disable iff (!aresetn)
         st_ff.debug_pin_enable && st_ff.chip_rstn && st_ff.bit_busy && st_ff.bit_drv_low &&
         st_ff.bit_cnt == DBG_SPEEDUP |=> st_ff.pad[PIN_DEBUG].oe && st_ff.pad[PIN_DEBUG].dout;
   endproperty
   a_speedup: assert property (p_speedup) else $error("no speed-up pulse");
   property p_rin_reset;
      @(posedge aclk) disable iff (!aresetn)
         st_ff.reset_input_pin_enable && !pin_s[PIN_RESET_IN] |=> !st_ff.chip_rstn ##1
            !st_ff.pad[PIN_RESET_IN].oe && st_ff.pad[PIN_RESET_IN].pull;
   endproperty
   a_rin_reset: assert property (p_rin_reset) else $error("reset input ignored");
   // force write pending, which restarts the reset count
   logic wr_force;
   assign wr_force = st_ff.aw_got && st_ff.w_got && st_ff.awaddr == OFS_FORCE;
   property p_mode_latch;
      @(posedge aclk) disable iff (!aresetn)
         !st_ff.chip_rstn && st_ff.rst_cnt == RST_HOLD_CYC - 4'h1 && !sys_reset_req &&
         !st_ff.reset_input_pin_enable && !wr_force
         |=> st_ff.bgnd == ($past(st_ff.mode_src) && !$past(pin_s[PIN_DEBUG]));
   endproperty
   a_mode_latch: assert property (p_mode_latch) else $error("mode latch wrong");
endmodule // rdp_pin_ctl

// File: rtl/rdp_pkg.sv
// shared constants and carrier types of the reset-out and debug pin control block
package rdp_pkg;
   // port geometry
   localparam int PORT_W = 8;
   localparam int NALT = 4;
   localparam int ADDR_W = 8;
   // positions of the shared system pins within the port
   localparam int PIN_RESET_OUT = 2; // port_c_bit_four
   localparam int PIN_DEBUG = 4; // port_a_bit_four, debug_mode_select_pin
   localparam int PIN_RESET_IN = 5; // port_a_bit_five
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_SYSOPT = 8'h00; // system_options_reg_one
   localparam logic [ADDR_W-1:0] OFS_FORCE = 8'h04; // debug_force_reset_reg
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DIR = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_DOUT = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_DIN = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PULL = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_DRIVE = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_SLEW = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_DBG_TX = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_DBG_RX = 8'h2C;
   // field positions
   localparam int BIT_RESET_OUT_EN = 0;
   localparam int BIT_RESET_IN_EN = 1;
   localparam int BIT_DEBUG_EN = 2;
   localparam int BIT_FORCE = 0;
   localparam int BIT_BGND = 0;
   localparam int BIT_TX_BUSY = 1;
   localparam int BIT_RX_FULL = 2;
   // reset values
   localparam logic [PORT_W-1:0] GPIO_RST = 8'h00;
   localparam logic DEBUG_EN_RST = 1'b1;
   localparam logic SYNC_RST = 1'b1;
   // timing counts in bus clock cycles
   localparam int RST_CNT_W = 4;
   localparam logic [RST_CNT_W-1:0] RST_HOLD_CYC = 4'h8;
   localparam logic [3:0] DBG_BIT_LAST = 4'hF; // 16 cycles per bit
   localparam logic [3:0] DBG_DRV_FIRST = 4'h2;
   localparam logic [3:0] DBG_DRV_LAST = 4'hB;
   localparam logic [3:0] DBG_SAMPLE = 4'hA;
   localparam logic [3:0] DBG_SPEEDUP = 4'hC;
   localparam logic [3:0] DBG_BYTE_BITS = 4'h8;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // one pin's drive controls
   typedef struct packed {
      logic oe;
      logic dout;
      logic pull;
      logic drive;
      logic slew;
   } rdp_pad_t;
   // alternate function requests of one pin, index 3 has the highest priority
   typedef struct packed {
      logic [NALT-1:0] en;
      logic [NALT-1:0] oe;
      logic [NALT-1:0] dout;
   } rdp_alt_t;
endpackage

// File: rtl/rdp_sync.sv
// two-stage synchroniser for pin levels
`timescale 1ns/100ps
module rdp_sync #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   import rdp_pkg::*;
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } rdp_sync_state_t;
   rdp_sync_state_t st_ff;
   rdp_sync_state_t nxt_st;
   // first stage feeds only the second
   always_comb begin
      nxt_st.meta = d_i;
      nxt_st.sync = st_ff.meta;
      if (!aresetn) begin
         nxt_st = {(2 * W){SYNC_RST}};
      end
   end
   always_ff @(posedge aclk) begin
      st_ff <= nxt_st;
   end
   assign q_o = st_ff.sync;
endmodule // rdp_sync

// File: verif/rdp_host_model.sv
// debug host model sitting on the shared debug/mode-select line
`timescale 1ns/100ps
module rdp_host_model (
   input wire logic aclk,
   input rdp_pkg::rdp_pad_t dev_pad,
   output logic line
);
   import rdp_pkg::*;
   logic lo = 1'b0;
   logic hi = 1'b0;
   // wire level: host low, host speed-up, device drive, else the pull-up
   assign line = lo ? 1'b0 : hi ? 1'b1 : dev_pad.oe ? dev_pad.dout : 1'b1;
   // hold the line low around a reset to ask for background mode
   task automatic hold(input logic v);
      @(posedge aclk);
      lo <= v;
   endtask
   // one bit slot: short low sends 1, long low sends 0; seen is the line mid-slot
   task automatic slot(input logic b, output logic seen);
      @(posedge aclk);
      lo <= 1'b1;
      repeat (b ? 2 : 15) @(posedge aclk);
      lo <= 1'b0;
      hi <= 1'b1;
      @(posedge aclk);
      hi <= 1'b0;
      repeat (b ? 7 : 1) @(posedge aclk);
      seen = line;
      repeat (14) @(posedge aclk);
   endtask
endmodule // rdp_host_model

// File: verif/rdp_pin_ctl_test.sv
// self-checking bench for the reset-out and debug pin control block
`timescale 1ns/100ps
module rdp_pin_ctl_test;
   import rdp_pkg::*;
   localparam logic [7:0] OFS [5] = '{OFS_DIR, OFS_DOUT, OFS_PULL, OFS_DRIVE, OFS_SLEW};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, pins = 8'hFF, bt;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rd;
   logic rst_req = 1'b0, sn;
   rdp_alt_t [7:0] alt = '0;
   logic awready, wready, bvalid, arready, rvalid, chip_rst_n, bgnd, line;
   logic [1:0] bresp, rresp, rs, ex;
   logic [31:0] rdata;
   rdp_pad_t [7:0] pads;
   logic [7:0] v [5];
   int miscompares = 0, checked = 0, top;
   rdp_pin_ctl rdp_pin_ctl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sys_reset_req(rst_req), .pad_in({pins[7:5], line, pins[3:0]}), .alt_i(alt),
      .pad_o(pads), .chip_reset_n(chip_rst_n), .bgnd_mode(bgnd));
   rdp_host_model rdp_host_model_i (.aclk(aclk), .dev_pad(pads[PIN_DEBUG]), .line(line));
   // bus clock
   initial forever #10 aclk = ~aclk;
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // bus write, address and data offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   // bus read
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // wait for the internal reset to be released
   task automatic wait_up;
      int n;
      n = 0;
      repeat (2) @(posedge aclk);
      while (chip_rst_n !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      chk(n < 100, 1);
      // one edge more, so pads that follow the released reset have settled
      @(posedge aclk);
   endtask
   task automatic por(input logic ms);
      rdp_host_model_i.hold(ms);
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      wait_up;
      chk(bgnd, ms);
      rdp_host_model_i.hold(1'b0);
   endtask
   // pin state key: drive fields when driving, pull when not
   function automatic logic [3:0] key(input logic o, d, p, s, sl);
      return o ? {1'b1, d, s, sl} : {1'b0, p, 2'b00};
   endfunction
   // pin state key of a pad as the device drives it
   function automatic logic [3:0] pk(input rdp_pad_t p);
      return key(p.oe, p.dout, p.pull, p.drive, p.slew);
   endfunction
   // watchdog
   initial begin
      #1000000;
      miscompares++;
      test_done;
   end
   // main sequence
   initial begin
      void'($urandom(4460));
      por(1'b0);
      chk(pads[PIN_DEBUG].pull, 1);
      for (int k = 0; k < 8; k++) begin
         if (k != 4) chk(pk(pads[k]), 0);
      end
      axr(OFS_SYSOPT);
      chk(rd[2:0], 3'h4);
      repeat (6) begin
         pins <= 8'($urandom);
         for (int i = 0; i < 5; i++) begin
            v[i] = 8'($urandom);
            axw(OFS[i], {24'h0, v[i]}, rs);
         end
         repeat (4) @(posedge aclk);
         for (int k = 0; k < 8; k++) begin
            if (k != 4) begin
               chk(pk(pads[k]), key(v[0][k], v[1][k], v[2][k], v[3][k], v[4][k]));
            end
         end
         axr(OFS_DIN);
         chk(rd[7:0] & 8'hEF, ((v[0] & v[1]) | (~v[0] & pins)) & 8'hEF);
      end
      axw(8'h3C, 32'h1, rs);
      chk(rs, RESP_SLVERR);
      axr(8'h3C);
      chk(rs, RESP_SLVERR);
      chk(rd, 32'h0);
      axw(OFS_DIR, 32'h0, rs);
      axw(OFS_PULL, 32'h0, rs);
      for (int e = 1; e < 16; e++) begin
         alt[0] <= {4'(e), 4'($urandom), 4'($urandom)};
         repeat (3) @(posedge aclk);
         for (int j = 0; j < 4; j++) if (alt[0].en[j]) top = j;
         ex = {alt[0].oe[top], alt[0].oe[top] & alt[0].dout[top]};
         chk({pads[0].oe, pads[0].oe & pads[0].dout}, ex);
      end
      axr(OFS_DIN);
      chk(rd[0], pins[0]);
      alt <= '0;
      axw(OFS_SYSOPT, 32'h1, rs);
      repeat (2) @(posedge aclk);
      chk({pads[2].oe, pads[2].dout}, 2'b11);
      axw(OFS_SYSOPT, 32'h0, rs);
      axr(OFS_SYSOPT);
      chk(rd[2:0], 3'h1);
      chk(pads[PIN_DEBUG].pull, 0);
      rst_req <= 1'b1;
      @(posedge aclk);
      rst_req <= 1'b0;
      repeat (3) @(posedge aclk);
      chk({chip_rst_n, pads[2].oe, pads[2].dout}, 3'b010);
      wait_up;
      chk({pads[2].dout, pads[PIN_DEBUG].pull, bgnd}, 3'b110);
      axw(OFS_SYSOPT, 32'h2, rs);
      repeat (3) @(posedge aclk);
      chk({pads[5].oe, pads[5].pull, pads[2].oe}, 3'b011);
      pins[5] <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(chip_rst_n, 0);
      pins[5] <= 1'b1;
      wait_up;
      rdp_host_model_i.hold(1'b1);
      axw(OFS_FORCE, 32'h1, rs);
      wait_up;
      chk(bgnd, 1);
      rdp_host_model_i.hold(1'b0);
      axr(OFS_DBG_RX);
      axw(OFS_DBG_TX, 32'hA5, rs);
      for (int i = 0; i < 8; i++) begin
         rdp_host_model_i.slot(1'b1, sn);
         bt = {bt[6:0], sn};
      end
      chk(bt, 8'hA5);
      axr(OFS_DBG_RX);
      bt = 8'($urandom);
      for (int i = 7; i >= 0; i--) rdp_host_model_i.slot(bt[i], sn);
      axr(OFS_DBG_RX);
      chk(rd[7:0], bt);
      por(1'b1);
      chk(pads[2].oe, 0);
      test_done;
   end
endmodule // rdp_pin_ctl_test
